// File: design/acth_link.sv
// Link-domain end of the event handshake.
// Assumes the link logic waits for an answer before the next event.
module acth_link
   import acth_pkg::*;
(
   input wire logic lnk_clk,
   input wire logic rst,
   input wire logic evt_vld,
   input wire logic [1:0] evt_kind,
   input wire logic [7:0] evt_data,
   output logic busy,
   output logic rsp_vld,
   output logic rsp_ack,
   output logic [7:0] rsp_data,
   acth_xfer_if.lnk x
);
   typedef struct packed {
      logic busy; // Event in flight
      logic tgl; // Request toggle
      logic [1:0] kind; // Held event kind
      logic [7:0] data; // Held event byte
      logic q1, q2, q3; // Answer toggle synchroniser and edge stage
      logic vld; // Answer pulse
      logic ack;
      logic [7:0] rd;
   } acth_lnk_s;

   localparam acth_lnk_s LNK_RST = '{default: '0};

   acth_lnk_s r_r, r_nxt;

   // Accept one event at a time; answer when the system side toggles back
   always_comb begin
      r_nxt = r_r;
      r_nxt.vld = 1'b0;
      r_nxt.q1 = x.rsp_tgl;
      r_nxt.q2 = r_r.q1;
      r_nxt.q3 = r_r.q2;
      if (r_r.busy && (r_r.q2 ^ r_r.q3)) begin
         // Answer words were stable before the toggle crossed
         r_nxt.busy = 1'b0;
         r_nxt.vld = 1'b1;
         r_nxt.ack = x.rsp_ack;
         r_nxt.rd = x.rsp_data;
      end else if (!r_r.busy && evt_vld) begin
         // Events offered while busy are dropped
         r_nxt.busy = 1'b1;
         r_nxt.tgl = ~r_r.tgl;
         r_nxt.kind = evt_kind;
         r_nxt.data = evt_data;
      end
   end

   // State register
   always_ff @(posedge lnk_clk or posedge rst) begin
      if (rst) begin
         r_r <= LNK_RST;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign busy = r_r.busy;
   assign rsp_vld = r_r.vld;
   assign rsp_ack = r_r.ack;
   assign rsp_data = r_r.rd;
   assign x.req_tgl = r_r.tgl;
   assign x.req_kind = r_r.kind;
   assign x.req_data = r_r.data;
endmodule

// File: design/acth_pkg.sv
// Constants, state codes and the check-byte function shared by the
// address resolution target logic.
// Assumes one system clock domain and one link clock domain.
//
// Overview of operation
// R1: Full device: all resolution commands, both resets.
// R2: Fixed discoverable: acknowledges assignment, keeps address.
// R3: Non-discoverable: directed read only; non-capable: nothing.
// R4: Prepare command 01h acknowledged, clears resolved flag.
// R5: Prepare cancels any pending controller notification.
// R6: Controller retries prepare or reset on refusal.
// R7: General reset 02h clears resolved, volatile valid.
// R8: Persistent keeps valid; default reloads address, sets valid.
// R9: Reset command draws a fresh random identifier part.
// R10: Resolution reset touches only resolution flags.
// R11: General identifier read answered only while unresolved.
// R12: Identifier read returns identifier, address, bit0 one.
// R13: Without valid address, upper seven bits all ones.
// R14: Controller reads refusal as nobody needing address.
// R15: Assignment: 04h, count 11h, identifier, address, check.
// R16: Assignment acknowledged; acted on only on full match.
// R17: Identifier mismatch refused at the current byte.
// R18: Controller treats refused assignment as device absent.
// R19: Match adopts address at once, bit0 ignored.
// R20: Matching assignment acted on even when resolved.
// R21: Bad check byte refused, assignment discarded.
// R22: Every packet: default address, command, check byte.
// R23: Controller checks returned byte count equals 11h.
// R24: Identifier, flags and address held from reset.
// R25: Default resolution address answered beside normal traffic.
package acth_pkg;
   localparam logic [6:0] ACTH_ARP_ADDR = 7'h61; // Default resolution address
   localparam logic [7:0] ACTH_CMD_PREP = 8'h01;
   localparam logic [7:0] ACTH_CMD_RST = 8'h02;
   localparam logic [7:0] ACTH_CMD_GET = 8'h03;
   localparam logic [7:0] ACTH_CMD_ASN = 8'h04;
   localparam logic [7:0] ACTH_CMD_DIR_MIN = 8'h20; // First directed command
   localparam logic [7:0] ACTH_CMD_DIR_MAX = 8'hfd; // Last directed command
   localparam logic [7:0] ACTH_BLK_CNT = 8'h11; // Identifier plus address
   localparam logic [4:0] ACTH_IDX_LAST_ID = 5'h0f; // Last identifier byte
   localparam logic [4:0] ACTH_IDX_ADDR = 5'h11; // Read: address byte slot
   localparam logic [4:0] ACTH_IDX_PEC = 5'h12; // Read: check byte slot
   localparam logic [6:0] ACTH_NO_ADDR = 7'h7f; // Shown while no valid address
   localparam logic [6:0] ACTH_ADDR_RST = 7'h00;
   localparam logic [7:0] ACTH_IDLE_RD = 8'hff; // Read data outside a frame
   localparam logic [7:0] ACTH_CRC_INIT = 8'h00;
   localparam logic [7:0] ACTH_CRC_POLY = 8'h07;
   localparam logic [31:0] ACTH_LFSR_SEED = 32'h0000_0001;
   localparam logic [31:0] ACTH_LFSR_TAPS = 32'h8020_0003;
   // Link event kinds
   localparam logic [1:0] ACTH_EV_START = 2'h0;
   localparam logic [1:0] ACTH_EV_WR = 2'h1;
   localparam logic [1:0] ACTH_EV_RD = 2'h2;
   localparam logic [1:0] ACTH_EV_STOP = 2'h3;
   // Device categories
   localparam logic [1:0] ACTH_CAT_FULL = 2'h0;
   localparam logic [1:0] ACTH_CAT_FIXD = 2'h1;
   localparam logic [1:0] ACTH_CAT_FIXND = 2'h2;
   localparam logic [1:0] ACTH_CAT_NONE = 2'h3;

   // Packet decoder states, one-hot
   typedef enum logic [7:0] {
      ACTH_ST_IDLE = 8'h01,
      ACTH_ST_CMD = 8'h02,
      ACTH_ST_CNT = 8'h04,
      ACTH_ST_ID = 8'h08,
      ACTH_ST_NADDR = 8'h10,
      ACTH_ST_PEC = 8'h20,
      ACTH_ST_RSTART = 8'h40,
      ACTH_ST_RD = 8'h80
   } acth_state_e;

   // One step of the CRC-8 packet check over a byte
   function automatic logic [7:0] acth_crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      for (int i = 0; i < 8; i++) begin
         x = x[7] ? ({x[6:0], 1'b0} ^ ACTH_CRC_POLY) : {x[6:0], 1'b0};
      end
      return x;
   endfunction
endpackage

// File: design/acth_top.sv
// Address resolution target: decodes resolution packets that a link
// front end delivers byte by byte, keeps the resolved and valid flags,
// the target address and the identifier, and answers every byte.
// Assumes configuration inputs are static straps on REF_CLK and that
// the link front end handles bit timing, start and stop detection.
module acth_top
   import acth_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic LINK_CLK,
   input wire logic LNK_EVT_VLD,
   input wire logic [1:0] LNK_EVT_KIND,
   input wire logic [7:0] LNK_EVT_DATA,
   output logic LNK_BUSY,
   output logic LNK_RSP_VLD,
   output logic LNK_RSP_ACK,
   output logic [7:0] LNK_RSP_DATA,
   input wire logic [1:0] CFG_CAT,
   input wire logic CFG_PTA,
   input wire logic CFG_DTA,
   input wire logic [6:0] CFG_DEF_ADDR,
   input wire logic [127:0] CFG_UDID,
   input wire logic CFG_RAND_EN,
   output logic [6:0] TGT_ADDR,
   output logic ADDR_RES,
   output logic ADDR_VALID,
   output logic PERSIST_WR,
   output logic NOTIFY_CANCEL
);
   // All system-domain state
   typedef struct packed {
      acth_state_e st; // Packet decoder state
      logic ar; // Address resolved
      logic av; // Address valid
      logic [6:0] addr; // Current target address
      logic [7:0] cmd; // Command of the packet in progress
      logic [4:0] idx; // Byte index inside identifier or read
      logic [7:0] crc; // Running packet check
      logic [6:0] naddr; // Assigned address awaiting check byte
      logic bad; // Frame refused, refuse the rest
      logic [31:0] rnd; // Random identifier part
      logic [31:0] lfsr; // Free running random source
      logic init; // Straps taken after reset release
      logic pwr; // Persistent store write pulse
      logic cancel; // Notification cancel pulse
      logic q1, q2, q3; // Request toggle synchroniser and edge stage
      logic tgl; // Answer toggle
      logic ack;
      logic [7:0] rd;
   } acth_sys_s;

   localparam acth_sys_s SYS_RST = '{
      st: ACTH_ST_IDLE,
      addr: ACTH_ADDR_RST,
      crc: ACTH_CRC_INIT,
      rnd: ACTH_LFSR_SEED,
      lfsr: ACTH_LFSR_SEED,
      rd: ACTH_IDLE_RD,
      default: '0
   };

   acth_sys_s r_r, r_nxt;
   acth_xfer_if xf ();

   logic [127:0] uid; // Identifier as currently seen on the bus
   logic [3:0] bsel; // Identifier byte number being compared or sent
   logic [7:0] ubyte; // That identifier byte
   logic [7:0] d; // Event byte
   logic arp_cap; // Category takes general commands
   logic dir_hit; // Directed command names our valid address
   logic crc_ok; // Received check byte matches

   // Link-domain half of the handshake
   acth_link u_link (
      .lnk_clk(LINK_CLK),
      .rst(RESET),
      .evt_vld(LNK_EVT_VLD),
      .evt_kind(LNK_EVT_KIND),
      .evt_data(LNK_EVT_DATA),
      .busy(LNK_BUSY),
      .rsp_vld(LNK_RSP_VLD),
      .rsp_ack(LNK_RSP_ACK),
      .rsp_data(LNK_RSP_DATA),
      .x(xf.lnk)
   );

   // Identifier with its random part, and byte selection
   always_comb begin
      uid = CFG_RAND_EN ? {CFG_UDID[127:32], r_r.rnd} : CFG_UDID; // R9
      if (r_r.st == ACTH_ST_RD) begin
         bsel = 4'(ACTH_IDX_LAST_ID - (r_r.idx - 5'h01));
      end else begin
         bsel = 4'(ACTH_IDX_LAST_ID - r_r.idx);
      end
      ubyte = uid[{bsel, 3'b000} +: 8];
      d = xf.req_data;
      arp_cap = (CFG_CAT == ACTH_CAT_FULL) || (CFG_CAT == ACTH_CAT_FIXD); // R1 R2
      dir_hit = r_r.av && (d[7:1] == r_r.addr);
      crc_ok = (d == r_r.crc);
   end

   // Packet decoding and flag updates
   always_comb begin
      r_nxt = r_r;
      r_nxt.pwr = 1'b0;
      r_nxt.cancel = 1'b0;
      r_nxt.q1 = xf.req_tgl;
      r_nxt.q2 = r_r.q1;
      r_nxt.q3 = r_r.q2;
      // Galois shift keeps the random source moving every cycle
      r_nxt.lfsr = {1'b0, r_r.lfsr[31:1]} ^ (r_r.lfsr[0] ? ACTH_LFSR_TAPS : 32'h0000_0000);
      if (!r_r.init) begin
         // Straps are read only after reset has let go
         r_nxt.init = 1'b1;
         if (CFG_DTA || CFG_PTA) begin
            r_nxt.addr = CFG_DEF_ADDR; // R24
            r_nxt.av = 1'b1; // R24
         end
      end else if (r_r.q2 ^ r_r.q3) begin
         // One event per toggle; answer always flips the toggle back
         r_nxt.tgl = ~r_r.tgl;
         r_nxt.ack = 1'b0;
         r_nxt.rd = ACTH_IDLE_RD;
         case (xf.req_kind)
            ACTH_EV_STOP: begin
               // Stop ends any frame; nothing half done is kept
               r_nxt.st = ACTH_ST_IDLE;
               r_nxt.bad = 1'b0;
            end
            ACTH_EV_START: begin
               if (r_r.st == ACTH_ST_RSTART && d == {ACTH_ARP_ADDR, 1'b1} && !r_r.bad) begin
                  // Repeated start turning the identifier read around
                  r_nxt.ack = 1'b1;
                  r_nxt.st = ACTH_ST_RD;
                  r_nxt.idx = 5'h00;
                  r_nxt.crc = acth_crc8(r_r.crc, d);
               end else if (d == {ACTH_ARP_ADDR, 1'b0} && CFG_CAT != ACTH_CAT_NONE) begin
                  // Only the default address is claimed here; traffic to
                  // the own target address is left to the normal function
                  r_nxt.ack = 1'b1; // R25 R22
                  r_nxt.st = ACTH_ST_CMD;
                  r_nxt.bad = 1'b0;
                  r_nxt.crc = acth_crc8(ACTH_CRC_INIT, d);
               end else begin
                  r_nxt.st = ACTH_ST_IDLE; // R3
                  r_nxt.bad = 1'b1;
               end
            end
            ACTH_EV_WR: begin
               r_nxt.crc = acth_crc8(r_r.crc, d);
               r_nxt.ack = 1'b1;
               r_nxt.st = ACTH_ST_PEC;
               r_nxt.cmd = d;
               case (r_r.st)
                  ACTH_ST_CMD: begin
                     if ((d == ACTH_CMD_PREP || d == ACTH_CMD_RST) && arp_cap) begin
                        r_nxt.st = ACTH_ST_PEC; // R4 R7
                     end else if (d == ACTH_CMD_GET && arp_cap && !r_r.ar) begin
                        r_nxt.st = ACTH_ST_RSTART; // R11
                     end else if (d == ACTH_CMD_ASN && arp_cap) begin
                        r_nxt.st = ACTH_ST_CNT; // R15
                     end else if (d >= ACTH_CMD_DIR_MIN && d <= ACTH_CMD_DIR_MAX
                                  && dir_hit && d[0] && CFG_CAT != ACTH_CAT_NONE) begin
                        r_nxt.st = ACTH_ST_RSTART; // R3
                     end else if (d >= ACTH_CMD_DIR_MIN && d <= ACTH_CMD_DIR_MAX
                                  && dir_hit && !d[0] && arp_cap) begin
                        r_nxt.st = ACTH_ST_PEC; // R1
                     end else begin
                        // Reserved, unsupported or refused command
                        r_nxt.ack = 1'b0; // R11
                        r_nxt.bad = 1'b1;
                        r_nxt.st = ACTH_ST_IDLE;
                     end
                  end
                  ACTH_ST_CNT: begin
                     r_nxt.cmd = r_r.cmd;
                     r_nxt.idx = 5'h00;
                     r_nxt.st = ACTH_ST_ID;
                     if (d != ACTH_BLK_CNT) begin
                        r_nxt.ack = 1'b0; // R15
                        r_nxt.bad = 1'b1;
                        r_nxt.st = ACTH_ST_IDLE;
                     end
                  end
                  ACTH_ST_ID: begin
                     // Compare high byte first; refuse at the first miss
                     r_nxt.cmd = r_r.cmd;
                     r_nxt.idx = r_r.idx + 5'h01;
                     r_nxt.st = (r_r.idx == ACTH_IDX_LAST_ID) ? ACTH_ST_NADDR : ACTH_ST_ID;
                     if (d != ubyte) begin
                        r_nxt.ack = 1'b0; // R16 R17
                        r_nxt.bad = 1'b1;
                        r_nxt.st = ACTH_ST_IDLE;
                     end
                  end
                  ACTH_ST_NADDR: begin
                     r_nxt.cmd = r_r.cmd;
                     r_nxt.naddr = d[7:1]; // R19
                  end
                  ACTH_ST_PEC: begin
                     // Check byte ends every write packet
                     r_nxt.cmd = r_r.cmd;
                     r_nxt.st = ACTH_ST_IDLE;
                     r_nxt.bad = 1'b1;
                     if (r_r.cmd == ACTH_CMD_ASN) begin
                        r_nxt.ack = crc_ok; // R21
                        if (crc_ok) begin
                           // Matches even when already resolved
                           r_nxt.ar = 1'b1; // R16 R20
                           r_nxt.av = 1'b1; // R16
                           if (CFG_CAT == ACTH_CAT_FULL) begin
                              r_nxt.addr = r_r.naddr; // R19
                              r_nxt.pwr = CFG_PTA; // R19
                           end
                        end
                     end else if (crc_ok && r_r.cmd == ACTH_CMD_PREP) begin
                        r_nxt.ar = 1'b0; // R4
                        r_nxt.cancel = 1'b1; // R5
                     end else if (crc_ok) begin
                        // General or directed reset: resolution state only
                        r_nxt.ar = 1'b0; // R7 R10
                        r_nxt.rnd = r_r.lfsr; // R9
                        if (CFG_DTA) begin
                           r_nxt.addr = CFG_DEF_ADDR; // R8
                           r_nxt.av = 1'b1; // R8
                        end else if (!CFG_PTA) begin
                           r_nxt.av = 1'b0; // R7
                        end
                     end
                  end
                  default: begin
                     // Write where none belongs, or a refused frame
                     r_nxt.cmd = r_r.cmd;
                     r_nxt.ack = 1'b0;
                     r_nxt.bad = 1'b1;
                     r_nxt.st = ACTH_ST_IDLE;
                  end
               endcase
            end
            default: begin
               // Read request: count, identifier, address, check byte
               if (r_r.st == ACTH_ST_RD) begin
                  r_nxt.ack = 1'b1;
                  r_nxt.idx = r_r.idx + 5'h01;
                  if (r_r.idx == 5'h00) begin
                     r_nxt.rd = ACTH_BLK_CNT; // R12
                  end else if (r_r.idx == ACTH_IDX_ADDR) begin
                     r_nxt.rd = {(r_r.av ? r_r.addr : ACTH_NO_ADDR), 1'b1}; // R12 R13
                  end else if (r_r.idx == ACTH_IDX_PEC) begin
                     r_nxt.rd = r_r.crc; // R22
                     r_nxt.st = ACTH_ST_IDLE;
                  end else begin
                     r_nxt.rd = ubyte; // R12
                  end
                  r_nxt.crc = acth_crc8(r_r.crc, r_nxt.rd);
               end
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         r_r <= SYS_RST; // R24
      end else begin
         r_r <= r_nxt;
      end
   end

   // Answer words back to the link domain
   assign xf.rsp_tgl = r_r.tgl;
   assign xf.rsp_ack = r_r.ack;
   assign xf.rsp_data = r_r.rd;

   // Flag and address outputs straight from state
   assign TGT_ADDR = r_r.addr;
   assign ADDR_RES = r_r.ar;
   assign ADDR_VALID = r_r.av;
   assign PERSIST_WR = r_r.pwr;
   assign NOTIFY_CANCEL = r_r.cancel;
endmodule

// File: design/acth_xfer_if.sv
// Toggle handshake carrying one link event and its answer between domains.
// Each side holds its words stable until the far side has toggled back.
interface acth_xfer_if;
   logic req_tgl; // Flips once per event, link domain
   logic [1:0] req_kind;
   logic [7:0] req_data;
   logic rsp_tgl; // Flips once per answer, system domain
   logic rsp_ack;
   logic [7:0] rsp_data;
   modport lnk (output req_tgl, req_kind, req_data, input rsp_tgl, rsp_ack, rsp_data);
   modport sys (input req_tgl, req_kind, req_data, output rsp_tgl, rsp_ack, rsp_data);
endinterface

// File: dv/acth_host.sv
// Controller model on the link side: one event in flight at a time.
// Keeps a running packet check over every byte sent or read.
module acth_host
   import acth_pkg::*;
(
   input wire logic lnk_clk,
   input wire logic rsp_vld,
   input wire logic rsp_ack,
   input wire logic [7:0] rsp_data,
   output logic evt_vld,
   output logic [1:0] evt_kind,
   output logic [7:0] evt_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] crc = 8'h00; // Check over the current packet
   logic tmo = 1'b0; // Set when an answer never came
   initial begin
      evt_vld = 1'b0;
      evt_kind = ACTH_EV_STOP;
      evt_data = 8'h00;
   end
   // Own copy of the check step, so a shared slip cannot hide
   function automatic logic [7:0] nxt(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      for (int i = 0; i < 8; i++) x = {x[6:0], 1'b0} ^ (x[7] ? 8'h07 : 8'h00);
      return x;
   endfunction
   // Offer at a falling edge, then wait a bounded time for the answer
   task automatic ev(input logic [1:0] k, input logic [7:0] d, output logic a,
                     output logic [7:0] rd);
      int n;
      @(negedge lnk_clk);
      evt_vld = 1'b1;
      evt_kind = k;
      evt_data = d;
      @(negedge lnk_clk);
      evt_vld = 1'b0;
      evt_data = ~d; // Released line shows no stale byte
      for (n = 0; n < 24 && rsp_vld !== 1'b1; n++) @(negedge lnk_clk);
      if (rsp_vld !== 1'b1) tmo = 1'b1;
      a = rsp_ack;
      rd = rsp_data;
      // Check covers address, command and data bytes alike
      if (k == ACTH_EV_STOP) crc = 8'h00;
      else crc = nxt(crc, k == ACTH_EV_RD ? rd : d);
   endtask
endmodule

// File: dv/acth_top_sva.sv
// Concurrent checks on the ports of the resolution target top.
// Assumes static straps and the link event timing of the hand-over.
module acth_sva_chk
   import acth_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic LINK_CLK,
   input wire logic LNK_EVT_VLD,
   input wire logic LNK_BUSY,
   input wire logic LNK_RSP_VLD,
   input wire logic [7:0] LNK_RSP_DATA,
   input wire logic [1:0] CFG_CAT,
   input wire logic CFG_PTA,
   input wire logic CFG_DTA,
   input wire logic [6:0] TGT_ADDR,
   input wire logic ADDR_RES,
   input wire logic ADDR_VALID,
   input wire logic PERSIST_WR,
   input wire logic NOTIFY_CANCEL
);
   a_take_busy: assert property (@(posedge LINK_CLK) disable iff (RESET)
      LNK_EVT_VLD && !LNK_BUSY |=> LNK_BUSY) else $error("busy not raised on a taken event");
   a_answer_bound: assert property (@(posedge LINK_CLK) disable iff (RESET)
      LNK_EVT_VLD && !LNK_BUSY |-> ##[4:16] LNK_RSP_VLD) else $error("event never answered");
   a_rsp_pulse: assert property (@(posedge LINK_CLK) disable iff (RESET)
      LNK_RSP_VLD |=> !LNK_RSP_VLD) else $error("answer strobe longer than one cycle");
   // Read data may only move together with an answer
   a_rsp_hold: assert property (@(posedge LINK_CLK) disable iff (RESET)
      $changed(LNK_RSP_DATA) |-> LNK_RSP_VLD) else $error("read data moved without answer");
   a_prep_clear: assert property (@(posedge REF_CLK) disable iff (RESET)
      NOTIFY_CANCEL |-> ##[0:2] !ADDR_RES) else $error("prepare left resolved flag set");
   a_res_valid: assert property (@(posedge REF_CLK) disable iff (RESET)
      $rose(ADDR_RES) |-> ADDR_VALID) else $error("resolved without valid address");
   // Persistent or default address devices never lose the valid flag
   a_pta_keep: assert property (@(posedge REF_CLK) disable iff (RESET)
      CFG_PTA || CFG_DTA |-> !$fell(ADDR_VALID)) else $error("valid flag lost");
   a_pers_pulse: assert property (@(posedge REF_CLK) disable iff (RESET)
      PERSIST_WR |-> ##[0:2] (CFG_PTA && ADDR_RES && ADDR_VALID))
      else $error("persistent store without assignment");
   // Fixed devices only move their address when leaving reset
   a_fixed_addr: assert property (@(posedge REF_CLK) disable iff (RESET)
      $changed(TGT_ADDR) && CFG_CAT != ACTH_CAT_FULL |-> $past(RESET, 2))
      else $error("fixed device changed its address");
endmodule

bind acth_top acth_sva_chk u_chk (.REF_CLK(REF_CLK), .RESET(RESET), .LINK_CLK(LINK_CLK),
   .LNK_EVT_VLD(LNK_EVT_VLD), .LNK_BUSY(LNK_BUSY), .LNK_RSP_VLD(LNK_RSP_VLD),
   .LNK_RSP_DATA(LNK_RSP_DATA), .CFG_CAT(CFG_CAT), .CFG_PTA(CFG_PTA), .CFG_DTA(CFG_DTA),
   .TGT_ADDR(TGT_ADDR), .ADDR_RES(ADDR_RES), .ADDR_VALID(ADDR_VALID),
   .PERSIST_WR(PERSIST_WR), .NOTIFY_CANCEL(NOTIFY_CANCEL));

// File: dv/arp_target_command_handler_test.sv
// Bench for the resolution target: host model on the link side,
// straps other than the random-part enable changed only under reset, flags and pulses seen on REF_CLK.
module arp_target_command_handler_test import acth_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic lnk_clk = 1'b0;
   logic rst = 1'b1;
   logic vld, busy, rvld, rack, pta = 1'b0, dta = 1'b0, ar, av, pwr, ncan, a, ren = 1'b0;
   logic [1:0] kind, cat = ACTH_CAT_FULL;
   logic [7:0] data, rdat, r;
   logic [6:0] tgt;
   logic [6:0] def = 7'h3a; // Default address strap
   logic [127:0] id = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
   int error_cnt = 0;
   int checked = 0;
   int pcnt = 0; // Persistent store pulses seen
   int ncnt = 0; // Notify cancel pulses seen
   always #20 ref_clk = ~ref_clk;
   // Link clock, offset so no edge lines up with the system clock
   initial begin
      #5;
      forever #16 lnk_clk = ~lnk_clk;
   end
   always @(posedge ref_clk) begin
      if (pwr === 1'b1) pcnt++;
      if (ncan === 1'b1) ncnt++;
   end
   acth_top u_dut (.REF_CLK(ref_clk), .RESET(rst), .LINK_CLK(lnk_clk), .LNK_EVT_VLD(vld),
      .LNK_EVT_KIND(kind), .LNK_EVT_DATA(data), .LNK_BUSY(busy), .LNK_RSP_VLD(rvld),
      .LNK_RSP_ACK(rack), .LNK_RSP_DATA(rdat), .CFG_CAT(cat), .CFG_PTA(pta), .CFG_DTA(dta),
      .CFG_DEF_ADDR(def), .CFG_UDID(id), .CFG_RAND_EN(ren), .TGT_ADDR(tgt), .ADDR_RES(ar),
      .ADDR_VALID(av), .PERSIST_WR(pwr), .NOTIFY_CANCEL(ncan));
   acth_host u_host (.lnk_clk(lnk_clk), .rsp_vld(rvld), .rsp_ack(rack), .rsp_data(rdat),
      .evt_vld(vld), .evt_kind(kind), .evt_data(data));
   task automatic conclude();
      $display("compared %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: expected %h got %h", $time, exp, got);
      end
   endtask
   // One event; a lost answer ends the run
   task automatic ev(input logic [1:0] k, input logic [7:0] d);
      u_host.ev(k, d, a, r);
      if (u_host.tmo) begin
         error_cnt++;
         conclude();
      end
   endtask
   // Write packet plus check byte; acks expected before index nak only
   task automatic pkt(input logic [7:0] q[$], input logic bad, input int nak);
      for (int i = 0; i <= q.size(); i++) begin
         ev(i == 0 ? ACTH_EV_START : ACTH_EV_WR, i < q.size() ? q[i] : u_host.crc ^ 8'(bad));
         chk(8'(i < nak), 8'(a));
      end
      ev(ACTH_EV_STOP, 8'h00);
   endtask
   task automatic asn(input logic [127:0] u, input logic [7:0] ad, input logic bad,
                      input int nak);
      logic [7:0] q[$];
      q = {8'hc2, 8'h04, 8'h11};
      for (int i = 15; i >= 0; i--) q.push_back(u[i*8 +: 8]);
      q.push_back(ad);
      pkt(q, bad, nak);
   endtask
   // General identifier read; ars predicts refusal of the command
   task automatic get(input logic ars, input logic [7:0] last);
      ev(ACTH_EV_START, 8'hc2);
      ev(ACTH_EV_WR, 8'h03);
      chk(8'(!ars), 8'(a));
      if (!ars) begin
         ev(ACTH_EV_START, 8'hc3);
         ev(ACTH_EV_RD, 8'h00);
         chk(8'h11, r);
         for (int i = 15; i >= 0; i--) begin
            ev(ACTH_EV_RD, 8'h00);
            chk(id[i*8 +: 8], r);
         end
         ev(ACTH_EV_RD, 8'h00);
         chk(last, r);
         ev(ACTH_EV_RD, 8'h00);
         chk(8'h00, u_host.crc);
      end
      ev(ACTH_EV_STOP, 8'h00);
   endtask
   // Flags, and the address unless it is undefined
   task automatic fl(input logic ear, input logic eav, input logic cka, input logic [6:0] ead);
      repeat (2) @(negedge ref_clk);
      chk({6'h0, ear, eav}, {6'h0, ar, av});
      if (cka) chk({1'b0, ead}, {1'b0, tgt});
   endtask
   // Straps only move while reset is held
   task automatic rst_to(input logic [1:0] c, input logic p, input logic d);
      @(negedge ref_clk);
      rst = 1'b1;
      cat = c;
      pta = p;
      dta = d;
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      repeat (3) @(negedge ref_clk);
   endtask
   task automatic t_full();
      int n;
      rst_to(ACTH_CAT_FULL, 1'b0, 1'b0);
      fl(1'b0, 1'b0, 1'b1, 7'h00);
      get(1'b0, 8'hff);
      asn(id ^ (128'h1 << 120), 8'h5b, 1'b0, 3);
      asn(id ^ (128'h1 << 8), 8'h5b, 1'b0, 17);
      asn(id, 8'h5b, 1'b1, 20);
      fl(1'b0, 1'b0, 1'b1, 7'h00);
      asn(id, 8'h5b, 1'b0, 21);
      fl(1'b1, 1'b1, 1'b1, 7'h2d);
      get(1'b1, 8'h00);
      asn(id, 8'h24, 1'b0, 21);
      fl(1'b1, 1'b1, 1'b1, 7'h12);
      n = ncnt;
      pkt({8'hc2, 8'h01}, 1'b0, 9);
      fl(1'b0, 1'b1, 1'b1, 7'h12);
      chk(8'(n + 1), 8'(ncnt));
      get(1'b0, 8'h25);
      pkt({8'hc2, 8'h02}, 1'b0, 9);
      fl(1'b0, 1'b0, 1'b0, 7'h00);
      $display("t_full done, %0d mismatches", error_cnt);
   endtask
   task automatic t_dta();
      rst_to(ACTH_CAT_FULL, 1'b0, 1'b1);
      fl(1'b0, 1'b1, 1'b1, def);
      asn(id, 8'h5b, 1'b0, 21);
      pkt({8'hc2, 8'h5a}, 1'b0, 9);
      fl(1'b0, 1'b1, 1'b1, def);
      pkt({8'hc2, 8'h02}, 1'b0, 9);
      fl(1'b0, 1'b1, 1'b1, def);
      $display("t_dta done, %0d mismatches", error_cnt);
   endtask
   task automatic t_pta();
      int n;
      rst_to(ACTH_CAT_FULL, 1'b1, 1'b0);
      n = pcnt;
      asn(id, 8'h5b, 1'b0, 21);
      chk(8'(n + 1), 8'(pcnt));
      pkt({8'hc2, 8'h02}, 1'b0, 9);
      fl(1'b0, 1'b1, 1'b1, 7'h2d);
      $display("t_pta done, %0d mismatches", error_cnt);
   endtask
   task automatic t_fixed();
      ren = 1'b1;
      rst_to(ACTH_CAT_FIXD, 1'b0, 1'b1);
      asn({id[127:32], ACTH_LFSR_SEED}, 8'h5b, 1'b0, 21);
      fl(1'b1, 1'b1, 1'b1, def);
      rst_to(ACTH_CAT_NONE, 1'b0, 1'b0);
      pkt({8'hc2, 8'h01}, 1'b0, 0);
      pkt({8'hc2, 8'h01}, 1'b0, 0);
      $display("t_fixed done, %0d mismatches", error_cnt);
   endtask
   initial begin
      t_full();
      t_dta();
      t_pta();
      t_fixed();
      conclude();
   end
endmodule
